// *** hdl/lfazc_ctrl.sv ***
// lf receiver auto-zero, error behaviour and carrier check control with ahb-lite registers
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module lfazc_ctrl
  import lfazc_pkg::*;
#(
  parameter int GRP_W = 4  // width of the carrier group count n
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             dataIn,              // demodulated data pin
  input  wire logic             dataFrameIn,         // receiver in data receive mode
  input  wire logic             summerAzEnIn,        // summer auto-zero enable
  input  wire logic             rxErrIn,             // receive error pulse level
  input  wire logic             onTimeLeftIn,        // on time remaining
  input  wire logic             deqActiveIn,         // analog de-q really active
  input  wire logic             carrierPktIn,        // one packet seen (level)
  input  wire logic [GRP_W-1:0] carrierDetectTimeIn, // group count n
  output logic                  autozeroStart,
  output logic                  autozeroLine,
  output logic                  onTimeEnd,
  output logic                  sniffReturn,
  output logic                  carrierValidation,
  output logic      [1:0]       thirdAmpGain,
  output logic      [1:0]       finalStageSelect,
  output logic      [1:0]       deqResistorSelect,
  output logic                  deqSystemEnable
);

  // register state
  logic       pageQ;       // page select
  logic [7:0] azccQ;       // auto-zero / carrier check control (bit 5 not stored)
  logic [7:0] fegdQ;       // front-end gain / de-q control
  logic [2:0] thrQ;        // edge-count threshold
  // bus data phase state
  logic       wrPendQ;
  logic       rdPendQ;
  logic [7:0] addrQ;
  // synchronisers for pins
  logic [1:0] dataS, azS, errS, onS, deq_active_status, pktS;
  // auto-zero counting
  logic [3:0] edgeCntQ;
  logic       dataPrevQ;
  logic [4:0] lfsrQ;
  logic [3:0] targetQ;
  logic [8:0] relCntQ;     // release countdown, wide enough for 1.5 rx periods
  logic       azPrevQ;
  logic       errPrevQ;
  // carrier packet timing
  logic [9:0] pktLenQ;
  logic       pktPrevQ;
  logic [2:0] pktIdxQ;
  logic [GRP_W-1:0] grpCntQ;

  // field helpers
  wire [1:0] relDelay = azccQ[LFAZC_RDLY_LSB +: 2];
  wire [1:0] trigMode = azccQ[LFAZC_TRIG_LSB +: 2];
  wire       errBehav = azccQ[LFAZC_ERRB_BIT];
  wire [1:0] chkMode  = azccQ[LFAZC_CHK_LSB +: 2];
  wire       busGo    = hsel && hready && htrans[1];

  // edge threshold with random offset: lfsr bits pick -1, 0 or +1
  function automatic logic [3:0] offsetThr(input logic [2:0] t, input logic [1:0] r);
    logic [3:0] b;
    b = {1'b0, t};
    if (r == 2'b00 && b != 4'h0) begin
      offsetThr = b - 4'h1;
    end else if (r == 2'b01) begin
      offsetThr = b + 4'h1;
    end else begin
      offsetThr = b;
    end
  endfunction : offsetThr

  // two-flop synchronisers on every pin input except dataFrameIn and carrierDetectTimeIn
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataS <= 2'h0; azS <= 2'h0; errS <= 2'h0;
      onS <= 2'h0; deq_active_status <= 2'h0; pktS <= 2'h0;
    end else begin
      dataS <= {dataS[0], dataIn};
      azS   <= {azS[0], summerAzEnIn};
      errS  <= {errS[0], rxErrIn};
      onS   <= {onS[0], onTimeLeftIn};
      deq_active_status  <= {deq_active_status[0], deqActiveIn};
      pktS  <= {pktS[0], carrierPktIn};
    end
  end

  // ahb address phase capture; zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPendQ <= 1'b0;
      rdPendQ <= 1'b0;
      addrQ   <= 8'h00;
    end else begin
      wrPendQ <= busGo && hwrite;
      rdPendQ <= busGo && !hwrite;
      if (busGo) begin
        addrQ <= haddr;
      end
    end
  end

  // register writes; paged registers only with page set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageQ <= LFAZC_PAGE_RST;
      azccQ <= LFAZC_AZCC_RST;
      fegdQ <= LFAZC_FEGD_RST;
      thrQ  <= LFAZC_THR_RST;
    end else if (wrPendQ) begin
      if (addrQ == LFAZC_OFS_PAGE) begin
        pageQ <= hwdata[0];
      end else if (addrQ == LFAZC_OFS_AZCC && pageQ) begin
        azccQ <= hwdata[7:0] & 8'hDF;
      end else if (addrQ == LFAZC_OFS_FEGD && pageQ) begin
        fegdQ <= hwdata[7:0];
      end else if (addrQ == LFAZC_OFS_THR && pageQ) begin
        thrQ <= hwdata[2:0];
      end
    end
  end

  // read data; paged locations read zero with page clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (busGo && !hwrite) begin
      if (haddr == LFAZC_OFS_PAGE) begin
        hrdata <= {31'h0, (wrPendQ && addrQ == LFAZC_OFS_PAGE) ? hwdata[0] : pageQ};
      end else if (haddr == LFAZC_OFS_AZCC && pageQ) begin
        hrdata <= {24'h0, azccQ[7:6], deq_active_status[1], azccQ[4:0]};
      end else if (haddr == LFAZC_OFS_FEGD && pageQ) begin
        hrdata <= {24'h0, fegdQ};
      end else if (haddr == LFAZC_OFS_THR && pageQ) begin
        hrdata <= {29'h0, thrQ};
      end else if (haddr == LFAZC_OFS_EVT) begin
        hrdata <= {28'h0, carrierValidation, sniffReturn, onTimeEnd, autozeroLine};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // bus answers: always ready, always okay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // front-end control outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thirdAmpGain      <= 2'h0;
      finalStageSelect  <= 2'h0;
      deqResistorSelect <= 2'h0;
      deqSystemEnable   <= 1'b0;
    end else begin
      thirdAmpGain      <= fegdQ[LFAZC_GAIN_LSB +: 2];
      finalStageSelect  <= fegdQ[LFAZC_FIN_LSB +: 2];
      deqResistorSelect <= fegdQ[LFAZC_RES_LSB +: 2];
      deqSystemEnable   <= fegdQ[LFAZC_DEQ_SYSTEM_ENABLE_BIT];
    end
  end

  // edge counting and trigger decision
  wire dataEdge = dataS[1] ^ dataPrevQ;
  wire thrHit   = edgeCntQ >= targetQ;
  logic trigOk;
  always_comb begin
    case (trigMode)
      2'b10:   trigOk = thrHit && !dataS[1];
      2'b11:   trigOk = thrHit && dataS[1];
      default: trigOk = thrHit;
    endcase
  end
  wire fire = dataFrameIn && fegdQ[LFAZC_DATA_AUTOZERO_ENABLE_BIT] && trigOk && !autozeroStart;

  // edge counter, target and lfsr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeCntQ  <= 4'h0;
      dataPrevQ <= 1'b0;
      lfsrQ     <= LFAZC_LFSR_RST;
      targetQ   <= {1'b0, LFAZC_THR_RST};
      autozeroStart <= 1'b0;
    end else begin
      dataPrevQ <= dataS[1];
      lfsrQ     <= {lfsrQ[3:0], lfsrQ[4] ^ lfsrQ[2]};
      autozeroStart <= fire;
      if (!dataFrameIn || fire) begin
        edgeCntQ <= 4'h0;
        targetQ  <= (trigMode == 2'b01) ? offsetThr(thrQ, lfsrQ[1:0]) : {1'b0, thrQ};
      end else if (dataEdge && edgeCntQ != 4'hF) begin
        edgeCntQ <= edgeCntQ + 4'h1;
      end
    end
  end

  // release delay: line follows summer enable rise, falls after delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      azPrevQ      <= 1'b0;
      relCntQ      <= 9'h000;
      autozeroLine <= 1'b0;
    end else begin
      azPrevQ <= azS[1];
      if (azS[1]) begin
        autozeroLine <= 1'b1;
        relCntQ      <= 9'h000;
      end else if (azPrevQ) begin
        case (relDelay)
          2'b10:   relCntQ <= 9'(LFAZC_HALF_CYC - 1);
          2'b11:   relCntQ <= 9'(LFAZC_THREE_HALF - 1);
          default: autozeroLine <= 1'b0;
        endcase
        if (relDelay[1] == 1'b0) begin
          relCntQ <= 9'h000;
        end
      end else if (relCntQ != 9'h000) begin
        relCntQ <= relCntQ - 9'h001;
      end else begin
        autozeroLine <= 1'b0;
      end
    end
  end

  // error behaviour on rising error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errPrevQ    <= 1'b0;
      onTimeEnd   <= 1'b0;
      sniffReturn <= 1'b0;
    end else begin
      errPrevQ    <= errS[1];
      onTimeEnd   <= errS[1] && !errPrevQ && !(errBehav && onS[1]);
      sniffReturn <= errS[1] && !errPrevQ && errBehav && onS[1];
    end
  end

  // carrier check: classify packet length, count per group
  wire       pktEnd  = pktPrevQ && !pktS[1];
  wire       isLong  = pktLenQ >= 10'(LFAZC_LONG_CYC - 1);
  wire       isShort = !isLong && pktLenQ >= 10'(LFAZC_SHORT_CYC - 1);
  logic       pktOk;
  logic       grpDone;
  always_comb begin
    case (chkMode)
      2'b01: begin
        pktOk   = (pktIdxQ == 3'h0) ? isLong : isShort;
        grpDone = pktIdxQ == 3'h4;
      end
      2'b10: begin
        pktOk   = isShort;
        grpDone = pktIdxQ == 3'h7;
      end
      default: begin
        pktOk   = isLong;
        grpDone = pktIdxQ == 3'h1;
      end
    endcase
  end

  // packet length measure and group counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pktPrevQ <= 1'b0;
      pktLenQ  <= 10'h000;
      pktIdxQ  <= 3'h0;
      grpCntQ  <= '0;
      carrierValidation <= 1'b0;
    end else begin
      pktPrevQ <= pktS[1];
      carrierValidation <= 1'b0;
      if (pktS[1]) begin
        if (pktLenQ != 10'h3FF) begin
          pktLenQ <= pktLenQ + 10'h001;
        end
      end else begin
        pktLenQ <= 10'h000;
      end
      if (pktEnd) begin
        if (!pktOk) begin
          pktIdxQ <= 3'h0;
          grpCntQ <= '0;
        end else if (grpDone) begin
          pktIdxQ <= 3'h0;
          if (grpCntQ + 1'b1 >= carrierDetectTimeIn) begin
            carrierValidation <= 1'b1;
            grpCntQ <= '0;
          end else begin
            grpCntQ <= grpCntQ + 1'b1;
          end
        end else begin
          pktIdxQ <= pktIdxQ + 3'h1;
        end
      end
    end
  end

  // checks
  a_deq_status_read: assert property (@(posedge clk) disable iff (rst)
    (busGo && !hwrite && haddr == LFAZC_OFS_AZCC && pageQ) |=> hrdata[5] == $past(deq_active_status[1]))
    else $error("de-q status read wrong");
  a_page_gate_write: assert property (@(posedge clk) disable iff (rst)
    (wrPendQ && !pageQ && addrQ == LFAZC_OFS_FEGD) |=> $stable(fegdQ))
    else $error("paged write with page clear");
  a_az_needs_en: assert property (@(posedge clk) disable iff (rst)
    $rose(autozeroStart) |-> $past(fegdQ[LFAZC_DATA_AUTOZERO_ENABLE_BIT]) && $past(dataFrameIn))
    else $error("auto-zero without enable");
  a_low_mode_data: assert property (@(posedge clk) disable iff (rst)
    ($rose(autozeroStart) && $past(trigMode) == 2'b10) |-> !$past(dataS[1]))
    else $error("mode 10 fired with data high");
  a_high_mode_data: assert property (@(posedge clk) disable iff (rst)
    ($rose(autozeroStart) && $past(trigMode) == 2'b11) |-> $past(dataS[1]))
    else $error("mode 11 fired with data low");
  a_thr_reached: assert property (@(posedge clk) disable iff (rst)
    $rose(autozeroStart) |-> $past(edgeCntQ) >= $past(targetQ))
    else $error("auto-zero before threshold");
  a_err_ends_on: assert property (@(posedge clk) disable iff (rst)
    (errS[1] && !errPrevQ && !errBehav) |=> onTimeEnd && !sniffReturn)
    else $error("error did not end on time");
  a_err_to_sniff: assert property (@(posedge clk) disable iff (rst)
    (errS[1] && !errPrevQ && errBehav && onS[1]) |=> sniffReturn && !onTimeEnd)
    else $error("error did not return to sniff");
  sequence s_rel_start;
    !azS[1] && azPrevQ && relDelay == 2'b10;
  endsequence
  a_rel_half: assert property (@(posedge clk) disable iff (rst)
    s_rel_start ##1 (!azS[1] && relDelay == 2'b10) [*8] |-> autozeroLine)
    else $error("release delay too short");
  a_deq_enable: assert property (@(posedge clk) disable iff (rst)
    ##1 deqSystemEnable == $past(fegdQ[LFAZC_DEQ_SYSTEM_ENABLE_BIT]))
    else $error("de-q enable mismatch");
endmodule : lfazc_ctrl

// *** hdl/lfazc_pkg.sv ***
// package: register map, field positions, reset values and timing for the lf auto-zero/carrier control block
package lfazc_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] LFAZC_OFS_PAGE  = 8'h00;  // page select register
  localparam logic [7:0] LFAZC_OFS_AZCC  = 8'h04;  // auto-zero / carrier check control
  localparam logic [7:0] LFAZC_OFS_FEGD  = 8'h08;  // front-end gain / de-q control
  localparam logic [7:0] LFAZC_OFS_THR   = 8'h0C;  // edge-count threshold
  localparam logic [7:0] LFAZC_OFS_EVT   = 8'h10;  // event/status view
  // field positions
  localparam int LFAZC_RDLY_LSB  = 6;   // release delay [7:6]
  localparam int LFAZC_DEQ_ACTIVE_STATUS_BIT  = 5;   // de-q active status
  localparam int LFAZC_TRIG_LSB  = 3;   // trigger mode [4:3]
  localparam int LFAZC_ERRB_BIT  = 2;   // error behaviour
  localparam int LFAZC_CHK_LSB   = 0;   // carrier check [1:0]
  localparam int LFAZC_GAIN_LSB  = 6;   // third amp gain [7:6]
  localparam int LFAZC_FIN_LSB   = 4;   // final stage [5:4]
  localparam int LFAZC_DATA_AUTOZERO_ENABLE_BIT  = 3;   // data auto-zero enable
  localparam int LFAZC_RES_LSB   = 1;   // de-q resistor [2:1]
  localparam int LFAZC_DEQ_SYSTEM_ENABLE_BIT = 0;   // de-q enable
  // reset values
  localparam logic [7:0] LFAZC_AZCC_RST = 8'h00;
  localparam logic [7:0] LFAZC_FEGD_RST = 8'h00;
  localparam logic [2:0] LFAZC_THR_RST  = 3'h6;
  localparam logic       LFAZC_PAGE_RST = 1'b0;
  localparam logic [4:0] LFAZC_LFSR_RST = 5'h15;
  // timing: system clock 25 MHz, receiver clock 125 kHz
  localparam int LFAZC_CLK_KHZ   = 25000;
  localparam int LFAZC_RX_KHZ    = 125;
  localparam int LFAZC_HALF_CYC  = (LFAZC_CLK_KHZ / LFAZC_RX_KHZ) / 2;      // half rx period
  localparam int LFAZC_THREE_HALF = 3 * LFAZC_HALF_CYC;                      // 1.5 rx periods
  // carrier check packet lengths in us
  localparam int LFAZC_LONG_US   = 32;
  localparam int LFAZC_SHORT_US  = 8;
  localparam int LFAZC_LONG_CYC  = LFAZC_LONG_US * LFAZC_CLK_KHZ / 1000;
  localparam int LFAZC_SHORT_CYC = LFAZC_SHORT_US * LFAZC_CLK_KHZ / 1000;
  // error handling outcomes
  typedef enum logic [1:0] {
    LFAZC_ERR_NONE  = 2'b00,
    LFAZC_ERR_END   = 2'b01,
    LFAZC_ERR_SNIFF = 2'b10
  } lfazc_err_t;
endpackage : lfazc_pkg

// *** tb/lfazc_fe_model.sv ***
// analog front end model: data edges, carrier packets, summer enable, errors, de-q feedback
`timescale 1ns/1ps
module lfazc_fe_model (
  input  wire logic clk,
  input  wire logic deqSystemEnable,
  output logic      dataIn,
  output logic      summerAzEnIn,
  output logic      rxErrIn,
  output logic      onTimeLeftIn,
  output logic      deqActiveIn,
  output logic      carrierPktIn
);
  // quiet front end at power-up
  initial begin
    {dataIn, summerAzEnIn, rxErrIn, onTimeLeftIn, deqActiveIn, carrierPktIn} = '0;
  end
  // de-q network reports active one cycle after its enable
  always @(posedge clk) begin
    deqActiveIn <= deqSystemEnable;
  end
  // wait n rising edges; every task is entered on a rising edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // n demodulated data edges, ten cycles apart
  task automatic edges(input int n);
    repeat (n) begin
      dataIn <= ~dataIn;
      hold(10);
    end
  endtask : edges
  // one carrier packet of len + 5 cycles, then a gap
  task automatic pkt(input int len);
    carrierPktIn <= 1'b1;
    hold(len + 5);
    carrierPktIn <= 1'b0;
    hold(20);
  endtask : pkt
  // one receive error of ten cycles
  task automatic err;
    rxErrIn <= 1'b1;
    hold(10);
    rxErrIn <= 1'b0;
    hold(10);
  endtask : err
  // summer auto-zero enable level
  task automatic sum(input logic v);
    summerAzEnIn <= v;
  endtask : sum
  // on time remaining level
  task automatic left(input logic v);
    onTimeLeftIn <= v;
  endtask : left
endmodule : lfazc_fe_model

// *** tb/tb.sv ***
// testbench: ahb-lite register access, front-end model traffic and output pulse checks
`timescale 1ns/1ps
module tb;
  import lfazc_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, dataFrameIn;
  logic [7:0]  haddr;
  logic [1:0]  htrans, thirdAmpGain, finalStageSelect, deqResistorSelect;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [3:0]  carrierDetectTimeIn;
  logic        dataIn, summerAzEnIn, rxErrIn, onTimeLeftIn, deqActiveIn, carrierPktIn;
  logic        autozeroStart, autozeroLine, onTimeEnd, sniffReturn, carrierValidation, deqSystemEnable;
  int          err_total = 0, comparisons = 0, cyc = 0;
  int          nAz = 0, nEnd = 0, nSniff = 0, nCar = 0;  // output pulse counts
  lfazc_ctrl i_lfazc_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dataIn(dataIn), .dataFrameIn(dataFrameIn), .summerAzEnIn(summerAzEnIn), .rxErrIn(rxErrIn),
    .onTimeLeftIn(onTimeLeftIn), .deqActiveIn(deqActiveIn), .carrierPktIn(carrierPktIn),
    .carrierDetectTimeIn(carrierDetectTimeIn), .autozeroStart(autozeroStart), .autozeroLine(autozeroLine),
    .onTimeEnd(onTimeEnd), .sniffReturn(sniffReturn), .carrierValidation(carrierValidation),
    .thirdAmpGain(thirdAmpGain), .finalStageSelect(finalStageSelect), .deqResistorSelect(deqResistorSelect),
    .deqSystemEnable(deqSystemEnable));
  lfazc_fe_model i_lfazc_fe_model (.clk(clk), .deqSystemEnable(deqSystemEnable), .dataIn(dataIn),
    .summerAzEnIn(summerAzEnIn), .rxErrIn(rxErrIn), .onTimeLeftIn(onTimeLeftIn), .deqActiveIn(deqActiveIn),
    .carrierPktIn(carrierPktIn));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // count one-cycle output pulses and cut a hang short
  always @(posedge clk) begin
    if (autozeroStart === 1'b1) nAz <= nAz + 1;
    if (onTimeEnd === 1'b1) nEnd <= nEnd + 1;
    if (sniffReturn === 1'b1) nSniff <= nSniff + 1;
    if (carrierValidation === 1'b1) nCar <= nCar + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  // compare seen against expected
  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : check
  // one ahb-lite single transfer, entered and left on a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hsize <= 3'b000;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    check(hresp, 32'h0, "hresp");
  endtask : ahb
  // register write and checked register read
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 8'h00, r);
    check(r, {24'h0, e}, "register read");
  endtask : rdc
  // paging, reset values, status bit, unmapped place
  task automatic t_regs;
    rdc(LFAZC_OFS_THR, 8'h00);
    wr(LFAZC_OFS_AZCC, 8'hFF);
    wr(LFAZC_OFS_PAGE, 8'h01);
    rdc(LFAZC_OFS_AZCC, LFAZC_AZCC_RST);
    rdc(LFAZC_OFS_FEGD, LFAZC_FEGD_RST);
    rdc(LFAZC_OFS_THR, 8'h06);
    wr(LFAZC_OFS_AZCC, 8'hFF);
    rdc(LFAZC_OFS_AZCC, 8'hDF);
    rdc(8'h80, 8'h00);
    wr(LFAZC_OFS_FEGD, 8'h01);
    i_lfazc_fe_model.hold(6);
    rdc(LFAZC_OFS_AZCC, 8'hFF);
    wr(LFAZC_OFS_THR, 8'h06);
    $display("test regs done");
  endtask : t_regs
  // every code of gain, final stage and resistor fields
  task automatic t_front;
    for (int i = 0; i < 4; i++) begin
      wr(LFAZC_OFS_FEGD, {i[1:0], ~i[1:0], 1'b0, i[1:0], i[0]});
      i_lfazc_fe_model.hold(2);
      check(thirdAmpGain, i[1:0], "gain");
      check(finalStageSelect, 2'(~i[1:0]), "final stage");
      check(deqResistorSelect, i[1:0], "resistor");
      check(deqSystemEnable, i[0], "de-q enable");
    end
    $display("test front done");
  endtask : t_front
  // error ends on time, or returns to sniff
  task automatic t_error;
    int e0, s0;
    e0 = nEnd;
    s0 = nSniff;
    wr(LFAZC_OFS_AZCC, 8'h00);
    i_lfazc_fe_model.err();
    check(nEnd - e0, 1, "on time end");
    i_lfazc_fe_model.left(1'b1);
    wr(LFAZC_OFS_AZCC, 8'h04);
    i_lfazc_fe_model.err();
    check(nSniff - s0, 1, "sniff return");
    check(nEnd - e0, 1, "no on time end");
    $display("test error done");
  endtask : t_error
  // new trigger mode with a fresh frame
  task automatic mode(input logic [1:0] m);
    dataFrameIn <= 1'b0;
    wr(LFAZC_OFS_AZCC, {3'b000, m, 3'b000});
    dataFrameIn <= 1'b1;
    i_lfazc_fe_model.hold(4);
  endtask : mode
  // n edges, then the count of auto-zero starts
  task automatic ed(input int n, input int e);
    int a0;
    a0 = nAz;
    i_lfazc_fe_model.edges(n);
    check(nAz - a0, e, "auto-zero starts");
  endtask : ed
  // auto-zero triggering in each mode
  task automatic t_az;
    int a0;
    wr(LFAZC_OFS_FEGD, 8'h08);
    mode(2'b00);
    ed(5, 0);
    ed(1, 1);
    mode(2'b10);
    ed(6, 1);
    mode(2'b11);
    ed(6, 0);
    ed(1, 1);
    ed(1, 0);
    mode(2'b01);
    a0 = nAz;
    i_lfazc_fe_model.edges(40);
    check((nAz - a0 >= 5) && (nAz - a0 <= 8), 1, "random starts");
    wr(LFAZC_OFS_FEGD, 8'h00);
    mode(2'b00);
    ed(12, 0);
    $display("test autozero done");
  endtask : t_az
  // release delay from summer fall to auto-zero line fall
  task automatic t_rel;
    int n, d;
    wr(LFAZC_OFS_FEGD, 8'h08);
    for (int c = 0; c < 4; c++) begin
      d = (c == 2) ? LFAZC_HALF_CYC : (c == 3) ? LFAZC_THREE_HALF : 0;
      wr(LFAZC_OFS_AZCC, {c[1:0], 6'b000000});
      i_lfazc_fe_model.sum(1'b1);
      i_lfazc_fe_model.hold(10);
      check(autozeroLine, 1, "line high");
      rdc(LFAZC_OFS_EVT, 8'h01);
      i_lfazc_fe_model.sum(1'b0);
      n = 0;
      while (autozeroLine !== 1'b0 && n < 400) begin
        @(negedge clk);
        n++;
      end
      @(posedge clk);
      check((n >= d) && (n <= d + 6), 1, "release delay");
    end
    $display("test release done");
  endtask : t_rel
  // carrier validation patterns over one, two or three groups
  task automatic t_car;
    int c0, k, n;
    dataFrameIn <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      n = (m == 1) ? 1 : (m == 3) ? 3 : 2;
      carrierDetectTimeIn <= 4'(n);
      wr(LFAZC_OFS_AZCC, {6'b000000, m[1:0]});
      k = (m == 2) ? 8 : (m == 1) ? 5 : 2;
      c0 = nCar;
      for (int p = 0; p < n * k; p++) begin
        if (p == n * k - 1) check(nCar - c0, 0, "early validation");
        i_lfazc_fe_model.pkt((m == 2 || (m == 1 && p % k != 0)) ? LFAZC_SHORT_CYC : LFAZC_LONG_CYC);
      end
      check(nCar - c0, 1, "validation");
    end
    $display("test carrier done");
  endtask : t_car
  // counts, verdict, end of run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // reset, then the scenarios
  initial begin
    rst = 1'b1;
    {hsel, hwrite, dataFrameIn} = '0;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'b000;
    carrierDetectTimeIn = 4'h2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_front();
    t_error();
    t_az();
    t_rel();
    t_car();
    give_verdict();
  end
endmodule : tb
